//--- hw/urr_rx.sv
// Local design decisions: the address map and the AHB-Lite slave port.
module urr_rx (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic [31:0]              hrdata,
  output logic                     hresp,
  input  wire logic                serial_input_pin,
  output logic                     irq
);
  import urr_pkg::*;

  typedef struct packed {
    urr_state_t       st;
    logic [4:0]       smp;
    logic [3:0]       idx;
    logic [1:0]       votes;
    logic [9:0]       shift;
    urr_entry_t [1:0] fifo;
    logic [1:0]       cnt;
    logic             rd_ptr;
    logic             ovr_pend;
    logic [7:0]       ctrl;
    logic [11:0]      baud;
    logic [2:0]       irq_st;
    logic [2:0]       irq_mask;
    logic             ap_valid;
    logic             ap_write;
    logic [7:0]       ap_addr;
    logic [31:0]      rdata;
    logic             ready;
    logic             irq;
  } urr_rx_t;

  urr_rx_t q;
  urr_rx_t d;

  logic       lvl;
  logic       tick;
  logic       dbl;
  logic       en;
  logic [4:0] spb;
  logic [4:0] first_s;
  logic [4:0] mid_s;
  logic [4:0] third_s;
  logic [2:0] size;
  logic [3:0] ndata;
  logic [3:0] nbits;
  logic       vote;
  logic       done;
  logic       stop_v;
  logic       ftype;
  logic       discard;
  logic       accept;
  logic       wr_idx;
  logic [8:0] dmask;
  logic       par_err;
  logic       addr_ph;
  logic       pop;
  urr_entry_t head;

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  urr_sampler u_smp (
    .hclk               (hclk),
    .hresetn            (hresetn),
    .serial_input_pin   (serial_input_pin),
    .run                (en),
    .baud_divisor_value (q.baud),
    .line_level         (lvl),
    .sample_tick        (tick)
  );

  // mode decode from the control register
  assign dbl   = q.ctrl[CTRL_DOUBLE];
  assign en    = q.ctrl[CTRL_EN];
  assign size  = (q.ctrl[CTRL_SIZE +: 3] > SIZE_MAX) ? SIZE_MAX : q.ctrl[CTRL_SIZE +: 3];
  assign ndata = 4'(size) + 4'h5;
  assign nbits = ndata + 4'(q.ctrl[CTRL_PAR_EN]);
  assign dmask = 9'h1FF >> (SIZE_MAX - size);

  assign spb     = dbl ? DBL_SPB : NORM_SPB;
  assign first_s = dbl ? DBL_FIRST : NORM_FIRST;
  assign mid_s   = dbl ? DBL_MID : NORM_MID;
  assign third_s = mid_s + 5'h01;

  // majority of the two held samples and the current one
  assign vote = maj3(q.votes[0], q.votes[1], lvl);

  assign done   = tick && q.st == ST_BITS && q.smp == third_s && q.idx == nbits;
  assign stop_v = vote;
  // frame type from ninth bit or first stop bit
  assign ftype  = (size == SIZE_MAX) ? q.shift[8] : stop_v;
  // filter drops data frames here; a full buffer also loses frames
  assign discard = done && q.ctrl[CTRL_FILTER] && !ftype;
  assign accept  = done && !discard;
  assign wr_idx  = q.rd_ptr ^ q.cnt[0];
  assign par_err = q.ctrl[CTRL_PAR_EN]
                 & ((^(q.shift[8:0] & dmask)) ^ q.shift[ndata] ^ q.ctrl[CTRL_PAR_ODD]);

  // bus decode: zero wait states, so hready marks the address phase
  assign addr_ph = hsel && htrans[1] && hready;
  assign pop     = addr_ph && !hwrite && haddr[7:0] == OFF_DATA && q.cnt != 2'h0;
  assign head    = q.fifo[q.rd_ptr];

  // next state of the whole block
  always_comb
  begin
    d = q;
    d.ready = 1'b1;

    // receive recovery machine
    if (tick)
    begin
      case (q.st)
        ST_IDLE:
        begin
          if (!lvl)
          begin
            d.st = ST_START;
            d.smp = 5'h01; // first low sample is state one
          end
        end
        ST_START:
        begin
          d.smp = q.smp + 5'h01;
          if (q.smp == first_s)
          begin
            d.votes[0] = lvl;
          end
          if (q.smp == mid_s)
          begin
            d.votes[1] = lvl;
          end
          if (q.smp == third_s && vote)
          begin
            d.st = ST_IDLE; // spike, not a start bit
          end
          else if (q.smp == spb)
          begin
            d.st = ST_BITS;
            d.smp = 5'h01;
            d.idx = 4'h0;
            d.shift = 10'h000;
          end
        end
        ST_BITS:
        begin
          // wrap the sample state at the bit length
          d.smp = (q.smp == spb) ? 5'h01 : q.smp + 5'h01;
          if (q.smp == spb)
          begin
            d.idx = q.idx + 4'h1;
          end
          if (q.smp == first_s)
          begin
            d.votes[0] = lvl;
          end
          if (q.smp == mid_s)
          begin
            d.votes[1] = lvl;
          end
          if (q.smp == third_s)
          begin
            if (q.idx == nbits)
            begin
              // back to idle right after the last stop vote
              d.st = ST_IDLE;
            end
            else
            begin
              d.shift[q.idx] = vote;
            end
          end
        end
        default:
        begin
          d.st = ST_IDLE;
        end
      endcase
    end

    // software read pops the head entry
    if (pop)
    begin
      d.rd_ptr = ~q.rd_ptr;
      d.cnt = q.cnt - 2'h1;
    end

    // store the frame with its error flags
    if (accept)
    begin
      if (q.cnt == 2'h2 && !pop)
      begin
        d.ovr_pend = 1'b1; // buffer full: frame lost, flag rides on next stored one
      end
      else
      begin
        d.fifo[wr_idx].data = q.shift[8:0] & dmask;
        d.fifo[wr_idx].ninth = ftype;
        d.fifo[wr_idx].fe = !stop_v;
        d.fifo[wr_idx].upe = par_err;
        d.fifo[wr_idx].dor = q.ovr_pend;
        d.ovr_pend = 1'b0;
        d.cnt = d.cnt + 2'h1;
      end
    end

    // bus data phase writes
    if (q.ap_valid && q.ap_write)
    begin
      case (q.ap_addr)
        OFF_CTRL:     d.ctrl = hwdata[7:0];
        OFF_BAUD:     d.baud = hwdata[11:0]; // divisor picks own rate error
        OFF_IRQ_STAT: d.irq_st = q.irq_st & ~hwdata[2:0];
        OFF_IRQ_MASK: d.irq_mask = hwdata[2:0];
        default:      d.ctrl = q.ctrl;
      endcase
    end

    // events set after the clear so a coincident event wins
    if (accept)
    begin
      d.irq_st[IRQ_RX] = 1'b1;
      if (!stop_v)
      begin
        d.irq_st[IRQ_FE] = 1'b1;
      end
      if (q.cnt == 2'h2 && !pop)
      begin
        d.irq_st[IRQ_OVR] = 1'b1;
      end
    end

    // disabling stops reception and flushes the buffer
    if (!d.ctrl[CTRL_EN])
    begin
      d.st = ST_IDLE;
      d.cnt = 2'h0;
      d.ovr_pend = 1'b0;
    end

    // address phase capture and registered read data
    d.ap_valid = addr_ph;
    d.ap_write = hwrite;
    d.ap_addr = haddr[7:0];
    d.rdata = 32'h0000_0000;
    if (addr_ph && !hwrite)
    begin
      case (haddr[7:0])
        OFF_CTRL:     d.rdata[7:0] = q.ctrl;
        OFF_BAUD:     d.rdata[11:0] = q.baud;
        OFF_DATA:     d.rdata[8:0] = (q.cnt != 2'h0) ? head.data : 9'h000;
        OFF_STAT:
        begin
          d.rdata[STAT_RXC] = q.cnt != 2'h0;
          d.rdata[STAT_FE] = (q.cnt != 2'h0) && head.fe;
          d.rdata[STAT_DOR] = (q.cnt != 2'h0) && head.dor;
          d.rdata[STAT_UPE] = (q.cnt != 2'h0) && head.upe;
          d.rdata[STAT_NINTH] = (q.cnt != 2'h0) && head.ninth;
          d.rdata[STAT_BUSY] = q.st != ST_IDLE;
        end
        OFF_IRQ_STAT: d.rdata[2:0] = q.irq_st;
        OFF_IRQ_MASK: d.rdata[2:0] = q.irq_mask;
        default:      d.rdata = 32'h0000_0000;
      endcase
    end

    d.irq = |(d.irq_st & d.irq_mask);
  end

  // single register stage for all state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.ctrl <= CTRL_RST;
      q.baud <= BAUD_RST;
      q.irq_mask <= MASK_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign hreadyout = q.ready;
  assign hrdata    = q.rdata;
  assign hresp     = 1'b0;
  assign irq       = q.irq;

  // named steps of a bit
  sequence s_third_vote;
    tick && q.st == ST_BITS && q.smp == third_s;
  endsequence

  sequence s_frame_end;
    s_third_vote ##0 q.idx == nbits;
  endsequence

  spb_wrap_a: assert property (tick && q.st == ST_BITS && q.smp == spb |=> q.smp == 5'h01)
    else $error("sample state did not wrap at bit length");

  first_vote_a: assert property (tick && q.st == ST_BITS && q.smp == first_s && en
    |=> q.votes[0] == $past(lvl))
    else $error("first voting sample not taken");

  mid_vote_a: assert property (tick && q.st != ST_IDLE && q.smp == mid_s && en
    |=> q.votes[1] == $past(lvl) && third_s == q.smp)
    else $error("middle voting sample not taken");

  bit_vote_a: assert property (s_third_vote ##0 q.idx < nbits && en
    |=> q.shift[$past(q.idx)] == maj3($past(q.votes[0]), $past(q.votes[1]), $past(lvl)))
    else $error("bit not set by majority");

  stop_idle_a: assert property (s_frame_end |=> q.st == ST_IDLE)
    else $error("receiver not idle after stop vote");

  fe_mark_a: assert property (accept && !stop_v && (q.cnt != 2'h2 || pop) && en
    |=> q.fifo[$past(wr_idx)].fe)
    else $error("frame error not stored");

  drop_keep_a: assert property (discard && !pop && en
    |=> $stable(q.cnt) && $stable(q.fifo) && $stable(q.irq_st[IRQ_FE]))
    else $error("dropped frame changed buffer");

  addr_take_a: assert property (accept && q.ctrl[CTRL_FILTER] && q.cnt == 2'h0 && en
    |=> q.cnt == 2'h1 && q.irq_st[IRQ_RX])
    else $error("address frame not accepted");

  ninth_sel_a: assert property (accept && size == SIZE_MAX && q.cnt == 2'h0 && en
    |=> q.fifo[$past(wr_idx)].ninth == $past(q.shift[8]))
    else $error("ninth bit not used as frame type");

  // interrupt follows masked status in the same or the next cycle
  irq_level_a: assert property (|(q.irq_st & q.irq_mask) |-> ##[0:1] irq)
    else $error("interrupt not raised");
endmodule

//--- shared/urr_pkg.sv
package urr_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_BAUD     = 8'h04;
  localparam logic [7:0] OFF_DATA     = 8'h08;
  localparam logic [7:0] OFF_STAT     = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

  // control field positions
  localparam int unsigned CTRL_FILTER  = 0;
  localparam int unsigned CTRL_DOUBLE  = 1;
  localparam int unsigned CTRL_EN      = 2;
  localparam int unsigned CTRL_SIZE    = 3;
  localparam int unsigned CTRL_PAR_EN  = 6;
  localparam int unsigned CTRL_PAR_ODD = 7;

  // status field positions
  localparam int unsigned STAT_RXC   = 0;
  localparam int unsigned STAT_FE    = 1;
  localparam int unsigned STAT_DOR   = 2;
  localparam int unsigned STAT_UPE   = 3;
  localparam int unsigned STAT_NINTH = 4;
  localparam int unsigned STAT_BUSY  = 5;

  // interrupt event positions
  localparam int unsigned IRQ_RX  = 0;
  localparam int unsigned IRQ_FE  = 1;
  localparam int unsigned IRQ_OVR = 2;

  // reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [11:0] BAUD_RST = 12'h000;
  localparam logic [2:0]  MASK_RST = 3'h0;

  // sample states per bit and voting positions
  localparam logic [4:0] NORM_SPB   = 5'h10;
  localparam logic [4:0] DBL_SPB    = 5'h08;
  localparam logic [4:0] NORM_FIRST = 5'h08;
  localparam logic [4:0] DBL_FIRST  = 5'h04;
  localparam logic [4:0] NORM_MID   = 5'h09;
  localparam logic [4:0] DBL_MID    = 5'h05;
  localparam logic [2:0] SIZE_MAX   = 3'h4;

  // accepted rate window for eight data-plus-parity bits, in hundredths of a percent
  localparam int unsigned NORM_SLOW_X100 = 9536;
  localparam int unsigned NORM_FAST_X100 = 10458;
  localparam int unsigned DBL_SLOW_X100  = 9600;
  localparam int unsigned DBL_FAST_X100  = 10390;
  localparam int unsigned OWN_ERR_X100   = 200;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BITS} urr_state_t;

  typedef struct packed {
    logic       upe;
    logic       dor;
    logic       fe;
    logic       ninth;
    logic [8:0] data;
  } urr_entry_t;
endpackage

//--- hw/urr_sampler.sv
module urr_sampler (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                serial_input_pin,
  input  wire logic                run,
  input  wire logic [11:0]         baud_divisor_value,
  output logic                     line_level,
  output logic                     sample_tick
);
  import urr_pkg::*;

  typedef struct packed {
    logic [2:0]  sync;
    logic        lvl;
    logic [11:0] div;
    logic        tick;
  } urr_smp_t;

  urr_smp_t q;
  urr_smp_t d;

  // three-stage sync; level moves only when stages two and three agree
  always_comb
  begin
    d = q;
    d.sync = {q.sync[1:0], serial_input_pin};
    if (q.sync[2] == q.sync[1])
    begin
      d.lvl = q.sync[2];
    end
    d.tick = 1'b0;
    if (!run)
    begin
      d.div = 12'h000;
    end
    else if (q.div == baud_divisor_value)
    begin
      d.div = 12'h000;
      d.tick = 1'b1; // one sample state per divisor+1 clocks
    end
    else
    begin
      d.div = q.div + 12'h001;
    end
  end

  // line idles high, so reset to high to avoid a false start
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '{sync: 3'h7, lvl: 1'b1, div: 12'h000, tick: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  assign line_level  = q.lvl;
  assign sample_tick = q.tick;
endmodule

//--- bench/urr_tx_model.sv
module urr_tx_model (
  input  wire logic hclk,
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ps;

  // the released line rests high, as if pulled up
  initial line = 1'b1;

  // one frame: start, nb bits lsb first, stop level, then optional idle
  // idle of zero leaves the stop level so a new start can follow at once
  task automatic send(input logic [8:0] d, input int nb, input logic stop,
                      input int bclk, input int stop_clk, input int idle);
    int i;
    @(posedge hclk);
    line <= 1'b0;
    repeat (bclk) @(posedge hclk);
    for (i = 0; i < nb; i++)
    begin
      line <= d[i];
      repeat (bclk) @(posedge hclk);
    end
    line <= stop;
    repeat (stop_clk) @(posedge hclk);
    if (idle > 0)
    begin
      line <= 1'b1;
      repeat (idle) @(posedge hclk);
    end
  endtask
endmodule

//--- bench/uart_rx_recovery_multiproc_test.sv
module uart_rx_recovery_multiproc_test;
  timeunit 1ns;
  timeprecision 1ps;
  import urr_pkg::*;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic [31:0] hrdata_s;
  logic        hresp;
  logic        line;
  logic        irq;
  logic [31:0] v;
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  urr_rx uut (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .hsel             (hsel),
    .haddr            (haddr),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hsize            (3'h2),
    .hwdata           (hwdata),
    .hready           (hreadyout),
    .hreadyout        (hreadyout),
    .hrdata           (hrdata),
    .hresp            (hresp),
    .serial_input_pin (line),
    .irq              (irq)
  );

  urr_tx_model tx (
    .hclk (hclk),
    .line (line)
  );

  // 125 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // keep the read data seen at each edge; cut a hang short
  always @(posedge hclk)
  begin
    hrdata_s <= hrdata;
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      failures++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // single ahb transfer; read data is the value held before the closing edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    #1 rd = hrdata_s;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0, d);
  endtask

  // status must be read before data, since the data read pops the head
  task automatic head(input logic [31:0] st, input logic [31:0] d);
    rd(OFF_STAT, v);
    chk(v, st);
    rd(OFF_DATA, v);
    chk(v, d);
  endtask

  // irq is registered on the same edge as the status and mask it follows
  task automatic irq_is(input logic e);
    repeat (2) @(posedge hclk);
    #1 chk({31'h0, irq}, {31'h0, e});
  endtask

  task automatic t_reset();
    wr(8'h18, 32'hFFFFFFFF);
    rd(8'h18, v);
    chk(v, 32'h0);
    rd(OFF_CTRL, v);
    chk(v, {24'h0, CTRL_RST});
    rd(OFF_BAUD, v);
    chk(v, {20'h0, BAUD_RST});
    rd(OFF_IRQ_MASK, v);
    chk(v, {29'h0, MASK_RST});
    chk({31'h0, hresp}, 32'h0);
    irq_is(1'b0);
  endtask

  task automatic t_basic();
    wr(OFF_BAUD, 32'h1);
    wr(OFF_CTRL, 32'h1C);
    tx.send(9'h0A5, 8, 1'b1, 32, 32, 32);
    head(32'h11, 32'hA5);
    tx.send(9'h03C, 8, 1'b0, 32, 32, 32);
    head(32'h03, 32'h3C);
    // even then odd parity; the ninth bit sent is the parity bit
    wr(OFF_CTRL, 32'h5C);
    tx.send(9'h1A5, 9, 1'b1, 32, 32, 32);
    head(32'h19, 32'hA5);
    wr(OFF_CTRL, 32'hDC);
    tx.send(9'h1A5, 9, 1'b1, 32, 32, 32);
    head(32'h11, 32'hA5);
    wr(OFF_CTRL, 32'h04);
    tx.send(9'h1F5, 5, 1'b1, 32, 64, 32);
    head(32'h11, 32'h15);
    wr(OFF_CTRL, 32'h1E);
    tx.send(9'h0C3, 8, 1'b1, 16, 16, 16);
    head(32'h11, 32'hC3);
  endtask

  // senders near the edges of the accepted rate window
  task automatic t_rate();
    wr(OFF_BAUD, 32'h3);
    wr(OFF_CTRL, 32'h1C);
    tx.send(9'h09A, 8, 1'b1, 62, 62, 64);
    head(32'h11, 32'h9A);
    tx.send(9'h065, 8, 1'b1, 67, 67, 64);
    head(32'h11, 32'h65);
    wr(OFF_CTRL, 32'h1E);
    tx.send(9'h0B4, 8, 1'b1, 31, 31, 32);
    head(32'h11, 32'hB4);
    tx.send(9'h04B, 8, 1'b1, 33, 33, 32);
    head(32'h11, 32'h4B);
  endtask

  // short stop bits, next start right after the stop votes; third frame overruns
  task automatic t_early();
    wr(OFF_BAUD, 32'h1);
    wr(OFF_CTRL, 32'h1C);
    wr(OFF_IRQ_STAT, 32'h7);
    tx.send(9'h055, 8, 1'b1, 32, 24, 0);
    tx.send(9'h0AA, 8, 1'b1, 32, 24, 0);
    tx.send(9'h0F0, 8, 1'b1, 32, 32, 32);
    rd(OFF_IRQ_STAT, v);
    chk(v & 32'h4, 32'h4);
    head(32'h11, 32'h55);
    head(32'h11, 32'hAA);
    // the frame stored after the loss carries the overrun mark
    tx.send(9'h0F0, 8, 1'b1, 32, 32, 32);
    head(32'h15, 32'hF0);
  endtask

  task automatic t_filter();
    wr(OFF_IRQ_STAT, 32'h7);
    wr(OFF_CTRL, 32'h1D);
    tx.send(9'h012, 8, 1'b0, 32, 32, 32);
    rd(OFF_STAT, v);
    chk(v, 32'h0);
    rd(OFF_IRQ_STAT, v);
    chk(v, 32'h0);
    tx.send(9'h007, 8, 1'b1, 32, 32, 32);
    head(32'h11, 32'h07);
    wr(OFF_CTRL, 32'h25);
    tx.send(9'h0AB, 9, 1'b1, 32, 32, 32);
    tx.send(9'h1CD, 9, 1'b1, 32, 32, 32);
    head(32'h11, 32'h1CD);
    wr(OFF_CTRL, 32'h24);
    tx.send(9'h034, 9, 1'b1, 32, 32, 32);
    head(32'h01, 32'h34);
  endtask

  task automatic t_irq();
    wr(OFF_CTRL, 32'h1C);
    wr(OFF_IRQ_STAT, 32'h7);
    wr(OFF_IRQ_MASK, 32'h0);
    tx.send(9'h081, 8, 1'b0, 32, 32, 32);
    irq_is(1'b0);
    rd(OFF_IRQ_STAT, v);
    chk(v, 32'h3);
    wr(OFF_IRQ_MASK, 32'h1);
    irq_is(1'b1);
    wr(OFF_IRQ_STAT, 32'h1);
    irq_is(1'b0);
    head(32'h03, 32'h81);
  endtask

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_reset();
    t_basic();
    t_rate();
    t_early();
    t_filter();
    t_irq();
    give_verdict();
  end
endmodule
